/* core/smme_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Interrupt request enters mode, acknowledge asserted
// - Resume restores image and releases acknowledge
// - State image lies within top 1056 bytes of bus space
// - Entry loads flags, debug control, pointer
// - Entry clears four control-zero bits only
// - Real addressing, 4G limits, 16-bit defaults
// - Default-size transfers truncate pointer to 16
// - Far targets limited to 20-bit bases
// - Interrupt, trap off; mask input ignored
// - NMI, init and debug traps disabled
// - Each saved item at fixed offset
// - Resume uses image as software modified
// - I/O trap pointer, source, count and destination slots filled only during I/O
// - Revision word with two capability bits
// - Reset sets region base default
// - Misaligned base at resume means shutdown
// - New base used until rewritten or reset
// - Halt slot reports and chooses halt return
// - Restart slot cleared; FFh re-executes I/O
module smme_ctrl #(
  parameter logic [15:0] REV_LEVEL = 16'h00A5  // Arbitrary revision level value
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chipset pins
  input  wire logic        mgmt_interrupt_request_n,
  output logic             mgmt_active_ack_n,
  // Core state at entry
  input  wire logic        resume_from_mgmt_instr,
  input  wire logic        core_halted,
  input  wire logic        io_cycle_valid,
  input  wire logic [31:0] core_control_reg_zero,
  input  wire logic [31:0] core_cr2,
  input  wire logic [31:0] core_cr3,
  input  wire logic [31:0] core_cr4,
  input  wire logic [31:0] core_flags_word,
  input  wire logic [31:0] core_instr_pointer,
  input  wire logic [31:0] core_eax,
  input  wire logic [31:0] core_dr6,
  input  wire logic [31:0] core_debug_control_reg,
  input  wire logic [31:0] core_io_trap_word,
  input  wire logic [31:0] core_io_trap_ip,
  input  wire logic [31:0] core_io_src,
  input  wire logic [31:0] core_io_cnt,
  input  wire logic [31:0] core_io_dst,
  // Entry loads to the core
  output logic             entry_load,
  output logic      [31:0] entry_flags_word,
  output logic      [31:0] entry_debug_control_reg,
  output logic      [31:0] entry_instr_pointer,
  output logic      [31:0] entry_control_reg_zero,
  output logic      [31:0] entry_code_base,
  output logic      [31:0] entry_data_seg_base,
  // Restore to the core
  output logic             restore_valid,
  output logic      [31:0] restore_control_reg_zero,
  output logic      [31:0] restore_cr2,
  output logic      [31:0] restore_cr3,
  output logic      [31:0] restore_cr4,
  output logic      [31:0] restore_flags_word,
  output logic      [31:0] restore_instr_pointer,
  output logic      [31:0] restore_eax,
  output logic      [31:0] restore_dr6,
  output logic      [31:0] restore_debug_control_reg,
  output logic      [31:0] restore_io_src,
  output logic      [31:0] restore_io_cnt,
  output logic      [31:0] restore_io_dst,
  output logic             restore_return_to_halt,
  output logic             restore_reexec_io,
  // Mode environment
  output logic             mode_active,
  output logic             mode_real_env,
  output logic             a20_mask_ignore,
  output logic             nmi_init_block,
  output logic             debug_trap_block,
  output logic             shutdown,
  // Control transfer checks
  input  wire logic [31:0] xfer_ip,
  input  wire logic        xfer_keeps_default,
  output logic      [31:0] xfer_ip_eff,
  input  wire logic [31:0] far_target_base,
  output logic             far_target_allowed
);

  smme_pkg::smme_state_type state_q;
  smme_pkg::smme_state_type state_d;

  logic [31:0] slot_q [smme_pkg::SLOT_COUNT];
  logic [31:0] active_base_q;
  logic [31:0] entry_cr0_q;
  logic        entry_load_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [31:0] xfer_ip_q;
  logic        far_ok_q;
  logic [31:0] rev_word;
  logic        apb_setup;
  logic        apb_wr;
  logic [4:0]  addr_slot;
  logic        addr_is_rev;
  logic        base_aligned;
  logic        in_mode;

  function automatic logic [4:0] slot_of(input logic [15:0] idx);
    unique case (idx)
      smme_pkg::IDX_CR0:    slot_of = smme_pkg::SL_CR0;
      smme_pkg::IDX_CR3:    slot_of = smme_pkg::SL_CR3;
      smme_pkg::IDX_FLAGS:  slot_of = smme_pkg::SL_FLAGS;
      smme_pkg::IDX_EIP:    slot_of = smme_pkg::SL_EIP;
      smme_pkg::IDX_EAX:    slot_of = smme_pkg::SL_EAX;
      smme_pkg::IDX_DR6:    slot_of = smme_pkg::SL_DR6;
      smme_pkg::IDX_DR7:    slot_of = smme_pkg::SL_DR7;
      smme_pkg::IDX_IOWORD: slot_of = smme_pkg::SL_IOWORD;
      smme_pkg::IDX_IOIP:   slot_of = smme_pkg::SL_IOIP;
      smme_pkg::IDX_CR2:    slot_of = smme_pkg::SL_CR2;
      smme_pkg::IDX_CR4:    slot_of = smme_pkg::SL_CR4;
      smme_pkg::IDX_IOSRC:  slot_of = smme_pkg::SL_IOSRC;
      smme_pkg::IDX_IOCNT:  slot_of = smme_pkg::SL_IOCNT;
      smme_pkg::IDX_IODST:  slot_of = smme_pkg::SL_IODST;
      smme_pkg::IDX_HALT:   slot_of = smme_pkg::SL_HALT;
      smme_pkg::IDX_IORST:  slot_of = smme_pkg::SL_IORST;
      smme_pkg::IDX_BASE:   slot_of = smme_pkg::SL_BASE;
      default:              slot_of = smme_pkg::SL_NONE;
    endcase
  endfunction

  // Byte-lane merge; the two half-word slots keep their upper bits at zero
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb, input logic [4:0] slot);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    if (slot == smme_pkg::SL_HALT || slot == smme_pkg::SL_IORST) begin
      res = res & smme_pkg::HALF_MASK;
    end
    merge_strb = res;
  endfunction

  // APB decode
  assign apb_setup    = psel & ~penable;
  assign apb_wr       = ce & psel & penable & pwrite;
  assign addr_slot    = slot_of(paddr[17:2]);
  assign addr_is_rev  = (paddr[17:2] == smme_pkg::IDX_REV);
  assign pready       = ce;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;

  assign rev_word = {14'h0000, 1'b1, 1'b1, REV_LEVEL};

  // Read data latched at setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce && apb_setup) begin
      pslverr_q <= (addr_slot == smme_pkg::SL_NONE) && !addr_is_rev;
      if (pwrite) begin
        prdata_q <= 32'h0000_0000;
      end else if (addr_is_rev) begin
        prdata_q <= rev_word;
      end else if (addr_slot != smme_pkg::SL_NONE) begin
        prdata_q <= slot_q[addr_slot];
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Mode sequencing
  assign base_aligned = (slot_q[smme_pkg::SL_BASE] & smme_pkg::BASE_ALIGN_MASK) == 32'h0000_0000;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      smme_pkg::ST_IDLE: begin
        if (!mgmt_interrupt_request_n) begin
          state_d = smme_pkg::ST_ENTER;
        end
      end
      smme_pkg::ST_ENTER: state_d = smme_pkg::ST_MODE;
      smme_pkg::ST_MODE: begin
        if (resume_from_mgmt_instr) begin
          state_d = smme_pkg::ST_EXIT;
        end
      end
      smme_pkg::ST_EXIT: begin
        state_d = base_aligned ? smme_pkg::ST_IDLE : smme_pkg::ST_SHUT;
      end
      smme_pkg::ST_SHUT: state_d = smme_pkg::ST_SHUT;
      default: state_d = smme_pkg::ST_SHUT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= smme_pkg::ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Acknowledge spans entry, the whole stay and the restore cycle
  assign in_mode = (state_q == smme_pkg::ST_ENTER) || (state_q == smme_pkg::ST_MODE) ||
                   (state_q == smme_pkg::ST_EXIT);
  assign mgmt_active_ack_n = ~in_mode;
  assign shutdown          = (state_q == smme_pkg::ST_SHUT);

  // Active base; only a resume with an aligned slot moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_base_q <= smme_pkg::BASE_RESET;
    end else if (ce && state_q == smme_pkg::ST_EXIT && base_aligned) begin
      active_base_q <= slot_q[smme_pkg::SL_BASE];
    end
  end

  // State image; entry capture comes last so it wins over a same-cycle bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < smme_pkg::SLOT_COUNT; i++) begin
        slot_q[i] <= 32'h0000_0000;
      end
      slot_q[smme_pkg::SL_BASE] <= smme_pkg::BASE_RESET;
    end else if (ce) begin
      if (apb_wr && addr_slot != smme_pkg::SL_NONE) begin
        slot_q[addr_slot] <= merge_strb(slot_q[addr_slot], pwdata, pstrb, addr_slot);
      end
      if (state_q == smme_pkg::ST_ENTER) begin
        slot_q[smme_pkg::SL_CR0]    <= core_control_reg_zero;
        slot_q[smme_pkg::SL_CR3]    <= core_cr3;
        slot_q[smme_pkg::SL_FLAGS]  <= core_flags_word;
        slot_q[smme_pkg::SL_EIP]    <= core_instr_pointer;
        slot_q[smme_pkg::SL_EAX]    <= core_eax;
        slot_q[smme_pkg::SL_DR6]    <= core_dr6;
        slot_q[smme_pkg::SL_DR7]    <= core_debug_control_reg;
        slot_q[smme_pkg::SL_IOWORD] <= core_io_trap_word;
        slot_q[smme_pkg::SL_CR2]    <= core_cr2;
        slot_q[smme_pkg::SL_CR4]    <= core_cr4;
        slot_q[smme_pkg::SL_HALT]   <= {31'h0000_0000, core_halted};
        slot_q[smme_pkg::SL_IORST]  <= {16'h0000, smme_pkg::IORST_CLEAR};
        slot_q[smme_pkg::SL_BASE]   <= active_base_q;
        if (io_cycle_valid) begin
          slot_q[smme_pkg::SL_IOIP]  <= core_io_trap_ip;
          slot_q[smme_pkg::SL_IOSRC] <= core_io_src;
          slot_q[smme_pkg::SL_IOCNT] <= core_io_cnt;
          slot_q[smme_pkg::SL_IODST] <= core_io_dst;
        end
      end
    end
  end

  // Entry loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_load_q <= 1'b0;
      entry_cr0_q  <= 32'h0000_0000;
    end else if (ce) begin
      entry_load_q <= (state_q == smme_pkg::ST_ENTER);
      if (state_q == smme_pkg::ST_ENTER) begin
        entry_cr0_q <= core_control_reg_zero & ~smme_pkg::CR0_CLEAR_MASK;
      end
    end
  end

  assign entry_load              = entry_load_q;
  assign entry_flags_word        = smme_pkg::FLAGS_ENTRY;
  assign entry_debug_control_reg = smme_pkg::DR7_ENTRY;
  assign entry_instr_pointer     = smme_pkg::EIP_ENTRY;
  assign entry_control_reg_zero  = entry_cr0_q;
  assign entry_code_base         = active_base_q;
  assign entry_data_seg_base     = smme_pkg::SEG_BASE_ENTRY;

  // Restore straight from the image, including any handler edits
  assign restore_valid             = (state_q == smme_pkg::ST_EXIT) && base_aligned;
  assign restore_control_reg_zero  = slot_q[smme_pkg::SL_CR0];
  assign restore_cr2               = slot_q[smme_pkg::SL_CR2];
  assign restore_cr3               = slot_q[smme_pkg::SL_CR3];
  assign restore_cr4               = slot_q[smme_pkg::SL_CR4];
  assign restore_flags_word        = slot_q[smme_pkg::SL_FLAGS];
  assign restore_instr_pointer     = slot_q[smme_pkg::SL_EIP];
  assign restore_eax               = slot_q[smme_pkg::SL_EAX];
  assign restore_dr6               = slot_q[smme_pkg::SL_DR6];
  assign restore_debug_control_reg = slot_q[smme_pkg::SL_DR7];
  assign restore_io_src            = slot_q[smme_pkg::SL_IOSRC];
  assign restore_io_cnt            = slot_q[smme_pkg::SL_IOCNT];
  assign restore_io_dst            = slot_q[smme_pkg::SL_IODST];
  assign restore_return_to_halt    = slot_q[smme_pkg::SL_HALT][smme_pkg::HALT_BIT];
  assign restore_reexec_io         = slot_q[smme_pkg::SL_IORST][15:0] == smme_pkg::IORST_REEXEC;

  // Environment levels while the mode lasts
  assign mode_active      = in_mode;
  assign mode_real_env    = in_mode;
  assign a20_mask_ignore  = in_mode;
  assign nmi_init_block   = in_mode;
  assign debug_trap_block = in_mode;

  // Transfer checks; registered, so results trail the request by one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_ip_q <= 32'h0000_0000;
      far_ok_q  <= 1'b1;
    end else if (ce) begin
      xfer_ip_q <= (in_mode && xfer_keeps_default) ? (xfer_ip & smme_pkg::IP16_MASK) : xfer_ip;
      far_ok_q  <= !in_mode || ((far_target_base & smme_pkg::FAR_BASE_MASK) == 32'h0000_0000);
    end
  end

  assign xfer_ip_eff        = xfer_ip_q;
  assign far_target_allowed = far_ok_q;

  a_ack_after_req: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_IDLE && !mgmt_interrupt_request_n) |=> !mgmt_active_ack_n)
    else $error("acknowledge missing after request");

  a_ack_release_resume: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_MODE && resume_from_mgmt_instr) ##1 (ce && base_aligned)
      |=> mgmt_active_ack_n)
    else $error("acknowledge not released after resume");

  a_ack_held_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(entry_load) |-> !mgmt_active_ack_n throughout (!mgmt_active_ack_n [*2]))
    else $error("acknowledge dropped inside the mode");

  a_entry_cr0_bits: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_ENTER) |=>
      ((entry_control_reg_zero & smme_pkg::CR0_CLEAR_MASK) == 32'h0000_0000) &&
      ((entry_control_reg_zero | smme_pkg::CR0_CLEAR_MASK) == ($past(core_control_reg_zero) | smme_pkg::CR0_CLEAR_MASK)))
    else $error("control zero entry value wrong");

  a_save_ip_slot: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_ENTER) |=> slot_q[smme_pkg::SL_EIP] == $past(core_instr_pointer))
    else $error("saved pointer slot wrong");

  a_io_slot_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_ENTER && !io_cycle_valid && !apb_wr) |=> $stable(slot_q[smme_pkg::SL_IOIP]))
    else $error("trap pointer written outside I/O cycle");

  a_restart_cleared: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_ENTER) |=> slot_q[smme_pkg::SL_IORST] == 32'h0000_0000 && !restore_reexec_io)
    else $error("restart slot not cleared on entry");

  a_misalign_shutdown: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_EXIT && !base_aligned) |=> shutdown && mgmt_active_ack_n)
    else $error("misaligned base did not shut down");

  a_base_relocate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && state_q == smme_pkg::ST_EXIT && base_aligned) |=> active_base_q == $past(slot_q[smme_pkg::SL_BASE]))
    else $error("relocated base not taken");

  a_rev_word_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && apb_setup && !pwrite && addr_is_rev) |=>
      prdata[17:16] == 2'b11 && prdata[31:18] == 14'h0000 && prdata[15:0] == REV_LEVEL)
    else $error("revision word wrong");

  a_ip_truncate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && in_mode && xfer_keeps_default) |=> xfer_ip_eff == ($past(xfer_ip) & smme_pkg::IP16_MASK))
    else $error("pointer not truncated in mode");

  a_block_in_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == smme_pkg::ST_MODE) |-> nmi_init_block && debug_trap_block && a20_mask_ignore)
    else $error("interrupt blocks missing in mode");

endmodule // smme_ctrl
`default_nettype wire

/* core/smme_pkg.sv */
`default_nettype none
package smme_pkg;

  // Save-area indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_CR0     = 16'hFFFC;
  localparam logic [15:0] IDX_CR3     = 16'hFFF8;
  localparam logic [15:0] IDX_FLAGS   = 16'hFFF4;
  localparam logic [15:0] IDX_EIP     = 16'hFFF0;
  localparam logic [15:0] IDX_EAX     = 16'hFFD0;
  localparam logic [15:0] IDX_DR6     = 16'hFFCC;
  localparam logic [15:0] IDX_DR7     = 16'hFFC8;
  localparam logic [15:0] IDX_IOWORD  = 16'hFFA4;
  localparam logic [15:0] IDX_IOIP    = 16'hFF9C;
  localparam logic [15:0] IDX_CR2     = 16'hFF14;
  localparam logic [15:0] IDX_CR4     = 16'hFF10;
  localparam logic [15:0] IDX_IOSRC   = 16'hFF0C;
  localparam logic [15:0] IDX_IOCNT   = 16'hFF08;
  localparam logic [15:0] IDX_IODST   = 16'hFF04;
  localparam logic [15:0] IDX_HALT    = 16'hFF02;
  localparam logic [15:0] IDX_IORST   = 16'hFF00;
  localparam logic [15:0] IDX_REV     = 16'hFEFC;
  localparam logic [15:0] IDX_BASE    = 16'hFEF8;

  // Slot numbers in the flip-flop image
  localparam int          SLOT_COUNT  = 17;
  localparam logic [4:0]  SL_CR0      = 5'h00;
  localparam logic [4:0]  SL_CR3      = 5'h01;
  localparam logic [4:0]  SL_FLAGS    = 5'h02;
  localparam logic [4:0]  SL_EIP      = 5'h03;
  localparam logic [4:0]  SL_EAX      = 5'h04;
  localparam logic [4:0]  SL_DR6      = 5'h05;
  localparam logic [4:0]  SL_DR7      = 5'h06;
  localparam logic [4:0]  SL_IOWORD   = 5'h07;
  localparam logic [4:0]  SL_IOIP     = 5'h08;
  localparam logic [4:0]  SL_CR2      = 5'h09;
  localparam logic [4:0]  SL_CR4      = 5'h0A;
  localparam logic [4:0]  SL_IOSRC    = 5'h0B;
  localparam logic [4:0]  SL_IOCNT    = 5'h0C;
  localparam logic [4:0]  SL_IODST    = 5'h0D;
  localparam logic [4:0]  SL_HALT     = 5'h0E;
  localparam logic [4:0]  SL_IORST    = 5'h0F;
  localparam logic [4:0]  SL_BASE     = 5'h10;
  localparam logic [4:0]  SL_NONE     = 5'h1F;

  // Values and fields
  localparam logic [31:0] BASE_RESET      = 32'h0003_0000;
  localparam logic [31:0] FLAGS_ENTRY     = 32'h0000_0002;
  localparam logic [31:0] DR7_ENTRY       = 32'h0000_0400;
  localparam logic [31:0] EIP_ENTRY       = 32'h0000_8000;
  localparam logic [31:0] SEG_BASE_ENTRY  = 32'h0000_0000;
  localparam logic [31:0] CR0_CLEAR_MASK  = 32'h8000_000D;
  localparam logic [31:0] HALF_MASK       = 32'h0000_FFFF;
  localparam logic [31:0] BASE_ALIGN_MASK = 32'h0000_7FFF;
  localparam logic [31:0] FAR_BASE_MASK   = 32'hFFF0_0000;
  localparam logic [31:0] IP16_MASK       = 32'h0000_FFFF;
  localparam logic [15:0] IORST_CLEAR     = 16'h0000;
  localparam logic [15:0] IORST_REEXEC    = 16'h00FF;
  localparam int          REV_RELOC_BIT   = 17;
  localparam int          REV_IOTRAP_BIT  = 16;
  localparam int          HALT_BIT        = 0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ENTER = 3'b001,
    ST_MODE  = 3'b010,
    ST_EXIT  = 3'b011,
    ST_SHUT  = 3'b100
  } smme_state_type;

endpackage
`default_nettype wire

/* verification/smme_chipset.sv */
`timescale 1ns/10ps
`default_nettype none
module smme_chipset (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench trigger and pins
  input  wire logic raise,
  input  wire logic mgmt_active_ack_n,
  output logic      mgmt_interrupt_request_n
);
  // Held low until acknowledged, so a slow answer still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mgmt_interrupt_request_n <= 1'b1;
    else if (raise) mgmt_interrupt_request_n <= 1'b0;
    else if (!mgmt_active_ack_n) mgmt_interrupt_request_n <= 1'b1;
  end
endmodule // smme_chipset
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        raise = 0, res = 0, io_v = 0, halt = 1, keep = 0, err;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, xip = '0, fbase = '0, rd, cv = 32'hA5A5_F00F;
  logic [31:0] prdata, e_fl, e_dr, e_ip, e_cr0, e_cb, e_ds, r_ip, x_eff, r_cr0, r_fl, r_src;
  logic        pready, pslverr, req_n, ack_n, e_ld, r_v, r_io, r_h;
  logic        m_a, m_r, a20, nmi, dbg, shut, far_ok;
  int          fails = 0, total_checks = 0;
  localparam logic [31:0] MSK = smme_pkg::CR0_CLEAR_MASK;
  localparam logic [31:0] NEWB = 32'h0004_0000;

  always #4 pclk = ~pclk;

  smme_chipset i_chip (.pclk(pclk), .presetn(presetn), .raise(raise), .mgmt_active_ack_n(ack_n),
    .mgmt_interrupt_request_n(req_n));

  smme_ctrl #(.REV_LEVEL(16'h00A5)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mgmt_interrupt_request_n(req_n), .mgmt_active_ack_n(ack_n), .resume_from_mgmt_instr(res),
    .core_halted(halt), .io_cycle_valid(io_v), .core_control_reg_zero(cv | MSK), .core_cr2(cv),
    .core_cr3(cv), .core_cr4(cv), .core_flags_word(cv), .core_instr_pointer(~cv), .core_eax(cv),
    .core_dr6(cv), .core_debug_control_reg(cv), .core_io_trap_word(cv), .core_io_trap_ip(~cv),
    .core_io_src(cv), .core_io_cnt(cv), .core_io_dst(cv), .entry_load(e_ld),
    .entry_flags_word(e_fl), .entry_debug_control_reg(e_dr), .entry_instr_pointer(e_ip),
    .entry_control_reg_zero(e_cr0), .entry_code_base(e_cb), .entry_data_seg_base(e_ds),
    .restore_valid(r_v), .restore_control_reg_zero(r_cr0), .restore_cr2(), .restore_cr3(),
    .restore_cr4(), .restore_flags_word(r_fl), .restore_instr_pointer(r_ip), .restore_eax(),
    .restore_dr6(), .restore_debug_control_reg(), .restore_io_src(r_src), .restore_io_cnt(),
    .restore_io_dst(), .restore_return_to_halt(r_h), .restore_reexec_io(r_io),
    .mode_active(m_a), .mode_real_env(m_r), .a20_mask_ignore(a20), .nmi_init_block(nmi),
    .debug_trap_block(dbg), .shutdown(shut), .xfer_ip(xip), .xfer_keeps_default(keep),
    .xfer_ip_eff(x_eff), .far_target_base(fbase), .far_target_allowed(far_ok));

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Called just after a rising edge; ends one edge after release
  task apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      finish_test;
    end
    @(posedge pclk);
  endtask

  // 0 ack low, 1 ack high, 2 entry load, 3 restore, 4 shutdown
  task wt(input int k);
    int n;
    n = 0;
    while (!(k == 0 ? ack_n === 1'b0 : k == 1 ? ack_n === 1'b1 : k == 2 ? e_ld === 1'b1 :
             k == 3 ? r_v === 1'b1 : shut === 1'b1) && n < 32) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 32) begin
      fails++;
      finish_test;
    end
  endtask

  task pulse_res;
    res <= 1'b1;
    @(posedge pclk);
    res <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(far_ok), 32'h0000_0001);
    apb(0, smme_pkg::IDX_BASE, 0);
    chk(rd, smme_pkg::BASE_RESET);
    apb(1, smme_pkg::IDX_REV, 32'hFFFF_FFFF);
    apb(0, smme_pkg::IDX_REV, 0);
    chk(rd, 32'h0003_00A5);
    apb(0, 16'h1234, 0);
    chk(32'(err), 32'h0000_0001);
    raise <= 1'b1;
    @(posedge pclk);
    raise <= 1'b0;
    wt(0);
    wt(2);
    chk(e_fl, smme_pkg::FLAGS_ENTRY);
    chk(e_dr, smme_pkg::DR7_ENTRY);
    chk(e_ip, smme_pkg::EIP_ENTRY);
    chk(e_ip & 32'hFFFF_8000, 32'h0000_8000);
    chk(e_ds, 32'h0000_0000);
    chk(e_cr0, cv & ~MSK);
    chk(32'({m_a, m_r, a20, nmi, dbg}), 32'h0000_001F);
    xip <= 32'h1234_5678;
    keep <= 1'b1;
    fbase <= 32'h0010_0000;
    repeat (2) @(posedge pclk);
    chk(x_eff, 32'h0000_5678);
    chk(32'(far_ok), 32'h0000_0000);
    apb(0, smme_pkg::IDX_CR0, 0);
    chk(rd, cv | MSK);
    apb(0, smme_pkg::IDX_EIP, 0);
    chk(rd, ~cv);
    apb(0, smme_pkg::IDX_IOWORD, 0);
    chk(rd, cv);
    apb(0, smme_pkg::IDX_IOIP, 0);
    chk(rd, 32'h0000_0000);
    chk(r_src, 32'h0000_0000);
    apb(0, smme_pkg::IDX_HALT, 0);
    chk(rd, 32'h0000_0001);
    chk(r_cr0, cv | MSK);
    chk(r_fl, cv);
    apb(1, smme_pkg::IDX_EIP, 32'h0000_1234);
    chk(r_ip, 32'h0000_1234);
    apb(1, smme_pkg::IDX_IORST, 32'h0000_00FF);
    apb(1, smme_pkg::IDX_HALT, 32'h0000_0000);
    apb(1, smme_pkg::IDX_BASE, NEWB);
    pulse_res;
    wt(3);
    chk(32'({r_io, r_h, ack_n}), 32'h0000_0004);
    wt(1);
    chk(e_cb, NEWB);
    cv <= 32'h5A5A_0FF0;
    io_v <= 1'b1;
    halt <= 1'b0;
    raise <= 1'b1;
    @(posedge pclk);
    raise <= 1'b0;
    wt(2);
    chk(e_cb, NEWB);
    apb(0, smme_pkg::IDX_BASE, 0);
    chk(rd, NEWB);
    apb(0, smme_pkg::IDX_IOIP, 0);
    chk(rd, ~cv);
    chk(r_src, cv);
    apb(0, smme_pkg::IDX_IORST, 0);
    chk(rd, 32'h0000_0000);
    apb(1, smme_pkg::IDX_BASE, NEWB | 32'h0000_0100);
    pulse_res;
    wt(4);
    chk(32'(ack_n), 32'h0000_0001);
    finish_test;
  end
endmodule // tb
`default_nettype wire
